/* verilog/serial_port_frame_logic.sv */
// Purpose: device side of a 16-bit framed serial port plus pin mode control
// Assumes: serial clock, frame select, data and pins are oversampled by clk
// Notes:   link edges are seen three clocks late; serial clock must stay well below clk/4
//
// Operation
// [R1] frame select low starts a frame; 16 falling serial edges carry the word
// [R2] serial_in is shifted in on each falling serial edge within a frame; the code shifts in only the first 16 falls
// [R3] host keeps serial clock at most 50 MHz writing, 20 MHz reading
// [R4] reset pin low returns all pin configuration to defaults
// [R5] frame select falling puts the outgoing word MSB on serial_out
// [R6] next bit leaves on the first rising edge after a falling edge
// [R7] serial_out returns conversion, read-back and temperature words
// [R8] each configurable pin acts as DAC, ADC, digital input or output
// [R9] configurable_pin_seven can show conversion busy when enabled
// [R10] first captured bit is MSB; serial edges outside frames are ignored
`timescale 1ns/1ps
module serial_port_frame_logic
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // link pins
  input  wire logic                 serial_clk,
  input  wire logic                 frame_sel_n,
  input  wire logic                 serial_in,
  output      logic                 serial_out,
  output      logic                 serial_out_oe,
  input  wire logic                 reset_pin_n,
  // received words
  output      logic                 rx_valid,
  output      logic [WORD_BITS-1:0] rx_data,
  // words to return: results, read-back, temperature
  input  wire logic                 tx_valid,
  output      logic                 tx_ready,
  input  wire logic [WORD_BITS-1:0] tx_data,
  // pin configuration
  input  wire logic                 cfg_mode_wr,
  input  wire logic [15:0]          cfg_mode_data,
  input  wire logic                 cfg_gpio_wr,
  input  wire logic [7:0]           cfg_gpio_data,
  input  wire logic                 cfg_busy_en_wr,
  input  wire logic                 cfg_busy_en_data,
  input  wire logic                 conv_busy,
  output      logic [7:0]           dac_sel,
  output      logic [7:0]           adc_sel,
  output      logic [7:0]           gpio_in,
  // configurable pins
  input  wire logic [7:0]           configurable_pin_in,
  output      logic [7:0]           configurable_pin_out,
  output      logic [7:0]           configurable_pin_oe
);
  // three-stage link synchronisers (two for configurable pins), a fourth stage for edge finding
  logic [1:0] sclk_m_q, sync_m_q, sdi_m_q, rpin_m_q;
  logic [7:0] pin_m_q, pin_s_q;
  logic       sclk_s_q, sclk_d_q, sync_s_q, sync_d_q, sdi_s_q, rpin_s_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_m_q <= '0; sync_m_q <= '1; sdi_m_q <= '0; rpin_m_q <= '1;
      sclk_s_q <= 1'b0; sync_s_q <= 1'b1; sdi_s_q <= 1'b0; rpin_s_q <= 1'b1;
      sclk_d_q <= 1'b0; sync_d_q <= 1'b1;
      pin_m_q  <= '0; pin_s_q <= '0;
    end else begin
      sclk_m_q <= {sclk_m_q[0], serial_clk};
      sync_m_q <= {sync_m_q[0], frame_sel_n};
      sdi_m_q  <= {sdi_m_q[0], serial_in};
      rpin_m_q <= {rpin_m_q[0], reset_pin_n};
      sclk_s_q <= sclk_m_q[1];
      sync_s_q <= sync_m_q[1];
      sdi_s_q  <= sdi_m_q[1];
      rpin_s_q <= rpin_m_q[1];
      sclk_d_q <= sclk_s_q;
      sync_d_q <= sync_s_q;
      pin_m_q  <= configurable_pin_in;
      pin_s_q  <= pin_m_q;
    end
  end

  // decode of the link
  wire frame       = ~sync_s_q;
  wire frame_start = sync_d_q & ~sync_s_q;
  wire sclk_fall   = sclk_d_q & ~sclk_s_q;
  wire sclk_rise   = ~sclk_d_q & sclk_s_q;
  wire cfg_rst     = srst | ~rpin_s_q;

  logic [CNT_W-1:0]     cnt_q;
  logic [WORD_BITS-1:0] rx_sh_q;
  logic [WORD_BITS-1:0] tx_sh_q;
  logic                 fell_q;
  logic                 out_q;
  logic                 rx_valid_q;
  logic [WORD_BITS-1:0] rx_data_q;

  wire capture  = frame & sclk_fall & (cnt_q != WORD_DONE);                     // R2 R10
  wire launch   = frame & ~frame_start & sclk_rise & fell_q;                    // R6
  wire word_end = capture & (cnt_q == WORD_LAST);                               // R1
  wire [WORD_BITS-1:0] rx_next = {rx_sh_q[WORD_BITS-2:0], sdi_s_q};             // R10

  // outgoing words wait here; an empty queue returns idle zeros
  logic                 fq_valid;
  logic [WORD_BITS-1:0] fq_data;
  wire  [WORD_BITS-1:0] tx_word = fq_valid ? fq_data : TX_IDLE_WORD;

  word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fq_valid),
    .out_ready (frame_start),
    .out_data  (fq_data)
  );

  always_ff @(posedge clk) begin
    if (srst || !frame) begin
      cnt_q   <= '0;                                                            // R10
      rx_sh_q <= '0;
    end else if (capture) begin
      cnt_q   <= cnt_q + 1'b1;                                                  // R1
      rx_sh_q <= rx_next;                                                       // R2
    end
  end

  // a rising edge only launches after a fall, so either idle level works
  always_ff @(posedge clk) begin
    if (srst || !frame) begin
      fell_q <= 1'b0;
    end else if (sclk_fall) begin
      fell_q <= 1'b1;                                                           // R6
    end else if (launch) begin
      fell_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_q   <= 1'b0;
      tx_sh_q <= '0;
    end else if (frame_start) begin
      out_q   <= tx_word[WORD_BITS-1];                                          // R5 R7
      tx_sh_q <= {tx_word[WORD_BITS-2:0], 1'b0};
    end else if (launch) begin
      out_q   <= tx_sh_q[WORD_BITS-1];                                          // R6
      tx_sh_q <= {tx_sh_q[WORD_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_valid_q <= 1'b0;
      rx_data_q  <= '0;
    end else begin
      rx_valid_q <= word_end;                                                   // R1
      if (word_end) rx_data_q <= rx_next;
    end
  end

  assign serial_out    = out_q;                                                 // R7
  assign serial_out_oe = frame;
  assign rx_valid      = rx_valid_q;
  assign rx_data       = rx_data_q;

  // pin configuration, cleared by the reset pin as well as srst
  logic [15:0] mode_q;
  logic [7:0]  gpio_q;
  logic        busy_en_q;
  logic [7:0]  pin_out_q, pin_oe_q, dac_q, adc_q, gin_q;

  always_ff @(posedge clk) begin
    if (cfg_rst) begin
      mode_q    <= MODE_RST;                                                    // R4
      gpio_q    <= GPIO_RST;
      busy_en_q <= BUSY_EN_RST;
    end else begin
      if (cfg_mode_wr)    mode_q    <= cfg_mode_data;
      if (cfg_gpio_wr)    gpio_q    <= cfg_gpio_data;
      if (cfg_busy_en_wr) busy_en_q <= cfg_busy_en_data;
    end
  end

  wire [7:0] pin_out_d, pin_oe_d, dac_d, adc_d, gin_d;

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    wire pin_mode_t m    = pin_mode_t'(mode_q[2*i +: 2]);
    wire            busy = (i == BUSY_PIN) && busy_en_q;
    assign dac_d[i]     = (m == PIN_DAC) & ~busy;                               // R8
    assign adc_d[i]     = (m == PIN_ADC) & ~busy;                               // R8
    assign gin_d[i]     = (m == PIN_DIN) & ~busy & pin_s_q[i];                  // R8
    assign pin_oe_d[i]  = busy | (m == PIN_DOUT);                               // R8 R9
    assign pin_out_d[i] = busy ? conv_busy : ((m == PIN_DOUT) & gpio_q[i]);     // R9
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_out_q <= '0; pin_oe_q <= '0; dac_q <= '0; adc_q <= '0; gin_q <= '0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
      dac_q     <= dac_d;
      adc_q     <= adc_d;
      gin_q     <= gin_d;
    end
  end

  assign configurable_pin_out = pin_out_q;
  assign configurable_pin_oe  = pin_oe_q;
  assign dac_sel              = dac_q;
  assign adc_sel              = adc_q;
  assign gpio_in              = gin_q;

  property p_capture;
    @(posedge clk) disable iff (srst) capture |=> rx_sh_q[0] == $past(sdi_s_q);
  endproperty
  a_capture: assert property (p_capture) else $error("bit not captured"); // R2

  property p_idle;
    @(posedge clk) disable iff (srst) (!frame && sclk_fall) |=> cnt_q == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("edge outside frame counted"); // R10

  property p_word;
    @(posedge clk) disable iff (srst)
      (capture && cnt_q == WORD_LAST) |=> rx_valid && rx_data == $past(rx_next);
  endproperty
  a_word: assert property (p_word) else $error("word not delivered after 16 bits"); // R1

  property p_msb;
    @(posedge clk) disable iff (srst)
      (frame_start && fq_valid) |=> serial_out == $past(fq_data[WORD_BITS-1]);
  endproperty
  a_msb: assert property (p_msb) else $error("msb not driven at frame start"); // R5

  property p_shift;
    @(posedge clk) disable iff (srst) launch |=> serial_out == $past(tx_sh_q[15]);
  endproperty
  a_shift: assert property (p_shift) else $error("bit not launched"); // R6

  property p_hold;
    @(posedge clk) disable iff (srst)
      (frame && !frame_start && !launch) |=> $stable(serial_out);
  endproperty
  a_hold: assert property (p_hold) else $error("serial_out moved off a launch"); // R6

  property p_cfg_rst;
    @(posedge clk) disable iff (srst)
      !rpin_s_q |=> mode_q == MODE_RST && !busy_en_q ##1 !configurable_pin_oe[BUSY_PIN];
  endproperty
  a_cfg_rst: assert property (p_cfg_rst) else $error("config not defaulted"); // R4

  property p_busy;
    @(posedge clk) disable iff (cfg_rst)
      busy_en_q |=> configurable_pin_oe[BUSY_PIN]
                    && configurable_pin_out[BUSY_PIN] == $past(conv_busy);
  endproperty
  a_busy: assert property (p_busy) else $error("busy pin wrong"); // R9

  property p_dout;
    @(posedge clk) disable iff (cfg_rst)
      (mode_q[1:0] == PIN_DOUT) |=> configurable_pin_oe[0]
                                    && configurable_pin_out[0] == $past(gpio_q[0]);
  endproperty
  a_dout: assert property (p_dout) else $error("digital output pin wrong"); // R8
endmodule : serial_port_frame_logic

/* shared/serial_port_pkg.sv */
// Purpose: shared constants and types of the serial port frame logic
// Assumes: one 50 MHz system clock samples every pin
// Notes:   pin mode codes are fixed here and used by the core and its bench
package serial_port_pkg;
  localparam int          WORD_BITS    = 16;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  WORD_LAST    = 5'h0f;
  localparam logic [4:0]  WORD_DONE    = 5'h10;
  localparam int          TX_DEPTH     = 4;
  localparam int          PIN_COUNT    = 8;
  localparam int          BUSY_PIN     = 7;
  // serial clock limits that the host keeps
  localparam int          LINK_WR_MHZ  = 50;
  localparam int          LINK_RD_MHZ  = 20;

  typedef enum logic [1:0] {
    PIN_DAC  = 2'b00,
    PIN_ADC  = 2'b01,
    PIN_DIN  = 2'b10,
    PIN_DOUT = 2'b11
  } pin_mode_t;

  localparam logic [15:0] MODE_RST     = 16'haaaa;
  localparam logic [7:0]  GPIO_RST     = 8'h00;
  localparam logic        BUSY_EN_RST  = 1'b0;
  localparam logic [15:0] TX_IDLE_WORD = 16'h0000;
endpackage : serial_port_pkg

/* verilog/word_fifo.sv */
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes:   depth must be a power of two
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // fill side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      fill_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (fill_q != (AW+1)'(DEPTH));
  assign out_valid = (fill_q != '0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q   <= '0;
      rd_q   <= '0;
      fill_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
      fill_q <= fill_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : word_fifo

/* dv/link_host.sv */
// Purpose: host controller model driving the framed serial link
// Assumes: 8 clk per serial clock period (160 ns)
// Notes:   data line is inverted when released; serial clock moves between frames only to a new idle level or in stray
`timescale 1ns/1ps
module link_host (
  // system clock
  input  wire logic clk,
  // link pins
  output      logic serial_clk,
  output      logic frame_sel_n,
  output      logic serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  // an undriven data line reads back inverted, so a late enable shows up as wrong bits
  wire line_seen = serial_out_oe ? serial_out : ~serial_out;
  initial begin
    serial_clk  = 1'b0;
    frame_sel_n = 1'b1;
    serial_in   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // 4 clk half periods give 6.25 MHz, inside both rate limits
  task automatic frame(input logic [15:0] w, input logic hi, input int n,
                       output logic [15:0] got);
    logic [15:0] sh;
    sh = w;
    got = 16'h0000;
    serial_clk <= hi;
    tick(4);
    frame_sel_n <= 1'b0;
    serial_in   <= sh[15];
    tick(4);
    for (int i = 0; i < n; i++) begin
      if (!hi) begin
        serial_clk <= 1'b1;
        tick(4);
      end
      serial_clk <= 1'b0;
      tick(2);
      // sampled mid-bit: the next bit leaves only at the following rise
      if (i < 16) got = {got[14:0], line_seen};
      tick(2);
      sh = sh << 1;
      serial_in <= sh[15];
      if (hi) begin
        serial_clk <= 1'b1;
        tick(4);
      end
    end
    tick(4);
    frame_sel_n <= 1'b1;
    serial_in   <= ~serial_in;
    tick(4);
  endtask : frame
  // clock edges with the frame select high, a deliberate fault
  task automatic stray(input int n);
    repeat (n) begin
      serial_clk <= ~serial_clk;
      tick(4);
    end
  endtask : stray
endmodule : link_host

/* dv/serial_port_frame_logic_tb.sv */
// Purpose: self-checking bench of the serial port frame logic
// Assumes: 50 MHz clk, link clock 160 ns from the host model
// Notes:   row table covers both idle levels; awkward cases follow
`timescale 1ns/1ps
module serial_port_frame_logic_tb;
  import serial_port_pkg::*;
  typedef struct packed {
    logic [15:0] tx;
    logic [15:0] rx;
    logic        hi;
  } row_t;
  row_t rows [4] = '{'{16'h8001, 16'h1234, 1'b0}, '{16'h7ffe, 16'hedcb, 1'b1},
                     '{16'hffff, 16'h0000, 1'b0}, '{16'h0000, 16'hffff, 1'b1}};
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        serial_clk, frame_sel_n, serial_in, serial_out, serial_out_oe;
  logic        reset_pin_n = 1'b1;
  logic        rx_valid, tx_ready;
  logic [15:0] rx_data, got;
  logic        tx_valid = 1'b0;
  logic [15:0] tx_data = 16'h0000;
  logic        cfg_mode_wr = 1'b0, cfg_gpio_wr = 1'b0, cfg_busy_en_wr = 1'b0;
  logic [15:0] cfg_mode_data = 16'h0000;
  logic [7:0]  cfg_gpio_data = 8'h00;
  logic        cfg_busy_en_data = 1'b0, conv_busy = 1'b0;
  logic [7:0]  dac_sel, adc_sel, gpio_in, pin_out, pin_oe;
  logic [7:0]  pin_in = 8'h5a;
  int          failures = 0, n_compared = 0, n_rx = 0, c0;

  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (rx_valid === 1'b1) n_rx <= n_rx + 1;
  end

  link_host host (.clk(clk), .serial_clk(serial_clk), .frame_sel_n(frame_sel_n),
                  .serial_in(serial_in), .serial_out(serial_out),
                  .serial_out_oe(serial_out_oe));
  serial_port_frame_logic uut (
    .clk(clk), .srst(srst), .serial_clk(serial_clk), .frame_sel_n(frame_sel_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .reset_pin_n(reset_pin_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .cfg_mode_wr(cfg_mode_wr), .cfg_mode_data(cfg_mode_data), .cfg_gpio_wr(cfg_gpio_wr),
    .cfg_gpio_data(cfg_gpio_data), .cfg_busy_en_wr(cfg_busy_en_wr),
    .cfg_busy_en_data(cfg_busy_en_data), .conv_busy(conv_busy), .dac_sel(dac_sel),
    .adc_sel(adc_sel), .gpio_in(gpio_in), .configurable_pin_in(pin_in),
    .configurable_pin_out(pin_out), .configurable_pin_oe(pin_oe));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  // valid stays high so back-to-back pushes never drop it for a cycle
  task automatic push(input logic [15:0] w);
    tx_data  <= w;
    tx_valid <= 1'b1;
    cyc(1);
    while (tx_ready !== 1'b1) cyc(1);
  endtask : push
  task automatic cfg(input logic [15:0] m, input logic [7:0] g, input logic b);
    cfg_mode_wr      <= 1'b1;
    cfg_mode_data    <= m;
    cfg_gpio_wr      <= 1'b1;
    cfg_gpio_data    <= g;
    cfg_busy_en_wr   <= 1'b1;
    cfg_busy_en_data <= b;
    cyc(1);
    cfg_mode_wr    <= 1'b0;
    cfg_gpio_wr    <= 1'b0;
    cfg_busy_en_wr <= 1'b0;
    cyc(4);
  endtask : cfg
  task automatic chk_dflt;
    check("dac_sel", 16'(dac_sel), 16'h0000);
    check("adc_sel", 16'(adc_sel), 16'h0000);
    check("pin_oe", 16'(pin_oe), 16'h0000);
    check("gpio_in", 16'(gpio_in), 16'h005a);
  endtask : chk_dflt

  initial begin
    cyc(20000);
    failures++;
    $display("watchdog expired");
    give_verdict();
  end

  initial begin
    cyc(12);
    srst <= 1'b0;
    cyc(4);
    check("tx_ready", 16'(tx_ready), 16'h0001);
    check("out_oe", 16'(serial_out_oe), 16'h0000);
    chk_dflt();
    $display("reset test done");
    foreach (rows[k]) begin
      push(rows[k].tx);
      tx_valid <= 1'b0;
      host.frame(rows[k].rx, rows[k].hi, 16, got);
      check("rx_data", rx_data, rows[k].rx);
      check("returned", got, rows[k].tx);
      check("rx count", 16'(n_rx), 16'(k + 1));
      check("out_oe", 16'(serial_out_oe), 16'h0000);
      $display("row %0d done", k);
    end
    for (int k = 0; k < 4; k++) push(16'h1000 + 16'(k));
    tx_data <= 16'h2000;
    cyc(3);
    check("tx_ready", 16'(tx_ready), 16'h0000);
    tx_valid <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      host.frame(16'h0f0f, 1'b0, 16, got);
      check("drained", got, (k < 4) ? 16'h1000 + 16'(k) : TX_IDLE_WORD);
    end
    $display("fifo test done");
    c0 = n_rx;
    host.stray(6);
    host.frame(16'h1357, 1'b0, 10, got);
    check("partial", 16'(n_rx - c0), 16'h0000);
    host.frame(16'hc3a5, 1'b1, 18, got);
    check("extra falls", rx_data, 16'hc3a5);
    check("one word", 16'(n_rx - c0), 16'h0001);
    $display("refusal test done");
    cfg(16'he4e4, 8'h08, 1'b0);
    check("dac_sel", 16'(dac_sel), 16'h0011);
    check("adc_sel", 16'(adc_sel), 16'h0022);
    check("pin_oe", 16'(pin_oe), 16'h0088);
    check("gpio_in", 16'(gpio_in), 16'h0040);
    check("pin_out", 16'(pin_out & pin_oe), 16'h0008);
    cfg(16'he4e4, 8'h08, 1'b1);
    conv_busy <= 1'b1;
    cyc(4);
    check("busy on", 16'(pin_out & pin_oe), 16'h0088);
    conv_busy <= 1'b0;
    cyc(4);
    check("busy off", 16'(pin_out & pin_oe), 16'h0008);
    cfg(16'hffff, 8'ha5, 1'b0);
    check("all out oe", 16'(pin_oe), 16'h00ff);
    check("all out", 16'(pin_out), 16'h00a5);
    reset_pin_n <= 1'b0;
    cyc(4);
    reset_pin_n <= 1'b1;
    cyc(4);
    chk_dflt();
    cfg(16'h5555, 8'hff, 1'b1);
    srst <= 1'b1;
    cyc(3);
    srst <= 1'b0;
    cyc(4);
    chk_dflt();
    $display("config test done");
    give_verdict();
  end
endmodule : serial_port_frame_logic_tb
